// File: rtl/lrm_core.sv
// How it works
// - fixed-zero bits always read back zero
// - time and alarm held as BCD digits
// - hours bit 6 selects 12-hour mode
// - bit 5 is PM or twenty-hours digit
// - weekday counts 1 to 7 repeatedly
// - february 29 when year multiple of four
// - month bit 7 toggles on year wrap
// - any write to 200h-213h during mission ends mission
// - alarm registers: mask bit plus BCD value
// - mask bits choose which fields must match
// - every alarm sets timer alarm flag
// - temperature byte, half-degree steps, max fah
// - out of range clamps to 00h or fah
// - sample interval minutes, 1 to 255
// - nonzero rate, cleared, not inhibited: start
// - control bit 5 reads zero always
// - bit 7 stops oscillator; start needs tick
// - clear arm dropped at next memory command
// - inhibit bit blocks mission start
// - wrap bit steers log overwrite
// - search bits select search conditions
// - start delay 16-bit minutes, low first
// - alarm and threshold flags cleared only by writing 0
// - threshold compares set low/high flags
module lrm_core
   import lrm_pkg::*;
#(
   parameter int SEC_CYC = LRM_SEC_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register page access from the memory command layer
   input wire logic i_wr,
   input wire logic [9:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_mem_cmd,
   input wire logic i_clear_cmd,
   // temperature converter
   input wire logic i_conv_valid,
   input wire logic signed [9:0] i_conv_raw,
   output logic [7:0] o_temp_code,
   // status to the logging and search logic
   output logic o_mission_active,
   output logic o_cleared_flag,
   output logic o_alarm_pulse,
   output logic o_sec_tick,
   output logic o_log_wrap_enable,
   output logic o_search_match,
   output logic [15:0] o_start_delay,
   output logic [7:0] o_sample_interval
);
   // clock and calendar digits
   logic [7:0] sec_r;
   logic [7:0] min_r;
   logic [7:0] hr_r;
   logic [7:0] wday_r;
   logic [7:0] date_r;
   logic [7:0] mon_r;
   logic [7:0] year_r;
   // alarm, threshold and mission setup
   logic [7:0] asec_r;
   logic [7:0] amin_r;
   logic [7:0] ahr_r;
   logic [7:0] awday_r;
   logic [7:0] tlo_r;
   logic [7:0] thi_r;
   logic [7:0] rate_r;
   logic [7:0] ctrl_r;
   logic [7:0] dlyl_r;
   logic [7:0] dlyh_r;
   // status flags
   logic mip_r;
   logic clr_r;
   logic tlf_r;
   logic thf_r;
   logic taf_r;
   logic ticked_r;
   logic [24:0] div_r;
   logic [7:0] temp_r, rdata_r;
   logic tick;

   // bcd digit increment with wrap
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   // last date of month in bcd
   function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = ~yr[4] ? (yr[1:0] == 2'b00) : (yr[1:0] == 2'b10);
      case (mon[4:0])
         5'h02: month_end = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: month_end = 8'h30;
         default: month_end = 8'h31;
      endcase
   endfunction

   // one-second divider, held at zero while oscillator stopped
   assign tick = ~ctrl_r[LRM_OSC_BIT] && (div_r == 25'(SEC_CYC - 1));
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_r <= '0;
      end else if (ctrl_r[LRM_OSC_BIT] || tick) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 25'd1;
      end
   end

   // carry chain
   wire sec_wrap = (sec_r[6:0] == 7'h59);
   wire min_wrap = sec_wrap && (min_r[6:0] == 7'h59);
   wire h12 = hr_r[LRM_H12_BIT];
   wire hr_wrap12 = h12 && (hr_r[4:0] == 5'h11) && hr_r[LRM_PM_BIT];
   wire hr_wrap24 = ~h12 && (hr_r[5:0] == 6'h23);
   wire day_wrap = min_wrap && (hr_wrap12 || hr_wrap24);
   wire [7:0] mend = month_end(mon_r, year_r);
   wire date_wrap = day_wrap && (date_r[5:0] == mend[5:0]);
   wire mon_wrap = date_wrap && (mon_r[4:0] == 5'h12);
   wire year_wrap = mon_wrap && (year_r == 8'h99);
   // digit increments kept as named words, a call result cannot be sliced
   wire [7:0] hr12_inc = bcd_inc({3'b000, hr_r[4:0]});
   wire [7:0] hr24_inc = bcd_inc({2'b00, hr_r[5:0]});
   wire [7:0] mon_inc = bcd_inc({3'b000, mon_r[4:0]});
   wire [7:0] date_inc = bcd_inc(date_r);
   wire [7:0] year_inc = bcd_inc(year_r);
   logic [7:0] hr_nxt;
   always_comb begin
      hr_nxt = hr_r;
      if (h12) begin
         // 12-hour: 11 -> 12 flips PM, 12 -> 01
         if (hr_r[4:0] == 5'h12) begin
            hr_nxt[4:0] = 5'h01;
         end else if (hr_r[4:0] == 5'h11) begin
            hr_nxt[4:0] = 5'h12;
            hr_nxt[LRM_PM_BIT] = ~hr_r[LRM_PM_BIT];
         end else begin
            hr_nxt[4:0] = hr12_inc[4:0];
         end
      end else begin
         hr_nxt[5:0] = hr_wrap24 ? 6'h00 : hr24_inc[5:0];
      end
   end

   // alarm compare on the value the clock is moving to
   logic [7:0] sec_nxt, min_nxt, hrn_nxt, wday_nxt;
   assign sec_nxt = sec_wrap ? 8'h00 : bcd_inc(sec_r);
   assign min_nxt = !sec_wrap ? min_r : ((min_r[6:0] == 7'h59) ? 8'h00 : bcd_inc(min_r));
   assign hrn_nxt = min_wrap ? hr_nxt : hr_r;
   assign wday_nxt = !day_wrap ? wday_r : ((wday_r[2:0] == 3'd7) ? 8'h01 : wday_r + 8'h01);
   wire s_eq = asec_r[LRM_MSK_BIT] || (asec_r[6:0] == sec_nxt[6:0]);
   wire m_eq = amin_r[LRM_MSK_BIT] || (amin_r[6:0] == min_nxt[6:0]);
   wire h_eq = ahr_r[LRM_MSK_BIT] || (ahr_r[6:0] == hrn_nxt[6:0]);
   wire d_eq = awday_r[LRM_MSK_BIT] || (awday_r[2:0] == wday_nxt[2:0]);
   // each mask relaxes one field; all set gives an alarm every second
   wire alarm = tick && s_eq && m_eq && h_eq && d_eq;
   assign o_alarm_pulse = alarm;
   assign o_sec_tick = tick;

   // register write decode
   wire prot_wr = i_wr && (i_addr >= LRM_SEC_ADR) && (i_addr <= LRM_LAST_PROT_ADR);
   wire stat_wr = i_wr && (i_addr == LRM_STAT_ADR);
   wire rate_wr = i_wr && (i_addr == LRM_RATE_ADR);
   // only clock addresses take priority over a tick; other writes must not freeze time
   wire clk_wr = i_wr && !mip_r && (i_addr >= LRM_SEC_ADR) && (i_addr <= LRM_YEAR_ADR);
   // start only outside a mission, so a write that ends one cannot restart it
   wire start = rate_wr && !mip_r && (i_wdata != 8'h00)
      && clr_r && !ctrl_r[LRM_INH_BIT]
      && ticked_r;
   wire end_mis = mip_r && prot_wr;

   // clock registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sec_r <= LRM_TIME_RST;
         min_r <= LRM_TIME_RST;
         hr_r <= LRM_TIME_RST;
         wday_r <= LRM_ONE_RST;
         date_r <= LRM_ONE_RST;
         mon_r <= LRM_ONE_RST;
         year_r <= LRM_TIME_RST;
      end else if (clk_wr) begin
         case (i_addr)
            LRM_SEC_ADR: sec_r <= i_wdata & LRM_SEC_MASK;
            LRM_MIN_ADR: min_r <= i_wdata & LRM_SEC_MASK;
            LRM_HR_ADR: hr_r <= i_wdata & LRM_HR_MASK;
            LRM_WDAY_ADR: wday_r <= i_wdata & LRM_WDAY_MASK;
            LRM_DATE_ADR: date_r <= i_wdata & LRM_DATE_MASK;
            LRM_MON_ADR: mon_r <= i_wdata & LRM_MON_MASK;
            LRM_YEAR_ADR: year_r <= i_wdata;
            default: ;
         endcase
      end else if (tick) begin
         sec_r <= sec_nxt;
         min_r <= min_nxt;
         hr_r <= hrn_nxt;
         wday_r <= wday_nxt;
         if (day_wrap) begin
            date_r <= date_wrap ? 8'h01 : date_inc;
         end
         if (date_wrap) begin
            mon_r[4:0] <= mon_wrap ? 5'h01 : mon_inc[4:0];
            if (year_wrap) begin
               mon_r[LRM_HUNDRED_YEAR_TOGGLE_BIT] <= ~mon_r[LRM_HUNDRED_YEAR_TOGGLE_BIT];
            end
         end
         if (mon_wrap) begin
            year_r <= year_wrap ? 8'h00 : year_inc;
         end
      end
   end

   // setup registers; during a mission the write only ends it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         asec_r <= LRM_TIME_RST;
         amin_r <= LRM_TIME_RST;
         ahr_r <= LRM_TIME_RST;
         awday_r <= LRM_TIME_RST;
         tlo_r <= LRM_TIME_RST;
         thi_r <= LRM_TIME_RST;
         rate_r <= LRM_TIME_RST;
         dlyl_r <= LRM_TIME_RST;
         dlyh_r <= LRM_TIME_RST;
      end else if (i_clear_cmd && ctrl_r[LRM_CLR_BIT] && !mip_r) begin
         rate_r <= LRM_TIME_RST;
         dlyl_r <= LRM_TIME_RST;
         dlyh_r <= LRM_TIME_RST;
      end else if (i_wr && !mip_r) begin
         case (i_addr)
            LRM_ASEC_ADR: asec_r <= i_wdata;
            LRM_AMIN_ADR: amin_r <= i_wdata;
            LRM_AHR_ADR: ahr_r <= i_wdata;
            LRM_AWDAY_ADR: awday_r <= i_wdata & LRM_AWDAY_MASK;
            LRM_TLO_ADR: tlo_r <= i_wdata;
            LRM_THI_ADR: thi_r <= i_wdata;
            LRM_RATE_ADR: rate_r <= i_wdata;
            LRM_DLYL_ADR: dlyl_r <= i_wdata;
            LRM_DLYH_ADR: dlyh_r <= i_wdata;
            default: ;
         endcase
      end
   end

   // control register; clear arm falls at the next memory command
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_r <= LRM_CTRL_RST;
      end else if (i_wr && !mip_r && (i_addr == LRM_CTRL_ADR)) begin
         ctrl_r <= i_wdata & LRM_CTRL_MASK;
      end else if (end_mis && (i_addr == LRM_CTRL_ADR)) begin
         ctrl_r <= i_wdata & LRM_CTRL_MASK;
      end else if (i_mem_cmd) begin
         ctrl_r[LRM_CLR_BIT] <= 1'b0;
      end
   end

   // oscillator must show a tick since last restart before a start counts
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ticked_r <= 1'b0;
      end else if (ctrl_r[LRM_OSC_BIT]) begin
         ticked_r <= 1'b0;
      end else if (tick) begin
         ticked_r <= 1'b1;
      end
   end

   // temperature clamp
   logic [7:0] code_nxt;
   assign code_nxt = (i_conv_raw < 10'sd0) ? LRM_TEMP_MIN :
                     (i_conv_raw > 10'sd250) ? LRM_TEMP_MAX : i_conv_raw[7:0];
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         temp_r <= LRM_TEMP_MIN;
      end else if (i_conv_valid) begin
         temp_r <= code_nxt;
      end
   end

   // status flags: hardware set wins over a software clear
   wire wr0_mip = stat_wr && !i_wdata[LRM_S_MIP_BIT];
   wire wr0_tlf = stat_wr && !i_wdata[LRM_S_TLF_BIT];
   wire wr0_thf = stat_wr && !i_wdata[LRM_S_THF_BIT];
   wire wr0_taf = stat_wr && !i_wdata[LRM_S_TAF_BIT];
   wire tl_set = mip_r && i_conv_valid && (code_nxt <= tlo_r);
   wire th_set = mip_r && i_conv_valid && (code_nxt >= thi_r);
   // a write of 1 never sets a flag; only hardware events do
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mip_r <= 1'b0;
      end else begin
         mip_r <= start || (mip_r && !end_mis && !wr0_mip);
      end
   end

   // cleared flag drops when the mission it enabled starts
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         clr_r <= 1'b0;
      end else if (start) begin
         clr_r <= 1'b0;
      end else if (i_clear_cmd && ctrl_r[LRM_CLR_BIT] && !mip_r) begin
         clr_r <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tlf_r <= 1'b0;
      end else begin
         tlf_r <= tl_set || (tlf_r && !wr0_tlf);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         thf_r <= 1'b0;
      end else begin
         thf_r <= th_set || (thf_r && !wr0_thf);
      end
   end

   // alarm cannot be disabled, so this flag is normally set in a mission
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         taf_r <= 1'b0;
      end else begin
         taf_r <= alarm || (taf_r && !wr0_taf);
      end
   end

   // read mux, registered
   logic [7:0] rd_mux;
   always_comb begin
      case (i_addr)
         LRM_SEC_ADR: rd_mux = sec_r;
         LRM_MIN_ADR: rd_mux = min_r;
         LRM_HR_ADR: rd_mux = hr_r;
         LRM_WDAY_ADR: rd_mux = wday_r;
         LRM_DATE_ADR: rd_mux = date_r;
         LRM_MON_ADR: rd_mux = mon_r;
         LRM_YEAR_ADR: rd_mux = year_r;
         LRM_ASEC_ADR: rd_mux = asec_r;
         LRM_AMIN_ADR: rd_mux = amin_r;
         LRM_AHR_ADR: rd_mux = ahr_r;
         LRM_AWDAY_ADR: rd_mux = awday_r;
         LRM_TLO_ADR: rd_mux = tlo_r;
         LRM_THI_ADR: rd_mux = thi_r;
         LRM_RATE_ADR: rd_mux = rate_r;
         LRM_CTRL_ADR: rd_mux = ctrl_r;
         LRM_DLYL_ADR: rd_mux = dlyl_r;
         LRM_DLYH_ADR: rd_mux = dlyh_r;
         LRM_STAT_ADR: rd_mux = {1'b1, clr_r, mip_r, 2'b00, tlf_r, thf_r, taf_r};
         default: rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_r <= 8'h00;
      end else if (i_rd) begin
         rdata_r <= rd_mux;
      end
   end

   assign o_rdata = rdata_r;
   assign o_temp_code = temp_r;
   assign o_mission_active = mip_r;
   assign o_cleared_flag = clr_r;
   assign o_log_wrap_enable = ctrl_r[LRM_WRAP_BIT];
   assign o_search_match = (ctrl_r[LRM_LSRCH_BIT] && tlf_r) || (ctrl_r[LRM_HSRCH_BIT] && thf_r)
                           || (ctrl_r[LRM_TSRCH_BIT] && taf_r);
   assign o_start_delay = {dlyh_r, dlyl_r};
   assign o_sample_interval = rate_r;
endmodule

// File: shared/lrm_pkg.sv
package lrm_pkg;
   // register page byte offsets
   localparam logic [9:0] LRM_SEC_ADR = 10'h200;
   localparam logic [9:0] LRM_MIN_ADR = 10'h201;
   localparam logic [9:0] LRM_HR_ADR = 10'h202;
   localparam logic [9:0] LRM_WDAY_ADR = 10'h203;
   localparam logic [9:0] LRM_DATE_ADR = 10'h204;
   localparam logic [9:0] LRM_MON_ADR = 10'h205;
   localparam logic [9:0] LRM_YEAR_ADR = 10'h206;
   localparam logic [9:0] LRM_ASEC_ADR = 10'h207;
   localparam logic [9:0] LRM_AMIN_ADR = 10'h208;
   localparam logic [9:0] LRM_AHR_ADR = 10'h209;
   localparam logic [9:0] LRM_AWDAY_ADR = 10'h20a;
   localparam logic [9:0] LRM_TLO_ADR = 10'h20b;
   localparam logic [9:0] LRM_THI_ADR = 10'h20c;
   localparam logic [9:0] LRM_RATE_ADR = 10'h20d;
   localparam logic [9:0] LRM_CTRL_ADR = 10'h20e;
   localparam logic [9:0] LRM_DLYL_ADR = 10'h212;
   localparam logic [9:0] LRM_DLYH_ADR = 10'h213;
   localparam logic [9:0] LRM_STAT_ADR = 10'h214;
   localparam logic [9:0] LRM_LAST_PROT_ADR = 10'h213;
   // writable bit masks (fixed-zero bits cleared)
   localparam logic [7:0] LRM_SEC_MASK = 8'h7f;
   localparam logic [7:0] LRM_HR_MASK = 8'h7f;
   localparam logic [7:0] LRM_WDAY_MASK = 8'h07;
   localparam logic [7:0] LRM_DATE_MASK = 8'h3f;
   localparam logic [7:0] LRM_MON_MASK = 8'h9f;
   localparam logic [7:0] LRM_AWDAY_MASK = 8'h87;
   localparam logic [7:0] LRM_CTRL_MASK = 8'hdf;
   // field positions
   localparam int LRM_MSK_BIT = 7;
   localparam int LRM_H12_BIT = 6;
   localparam int LRM_PM_BIT = 5;
   localparam int LRM_HUNDRED_YEAR_TOGGLE_BIT = 7;
   localparam int LRM_OSC_BIT = 7;
   localparam int LRM_CLR_BIT = 6;
   localparam int LRM_INH_BIT = 4;
   localparam int LRM_WRAP_BIT = 3;
   localparam int LRM_LSRCH_BIT = 2;
   localparam int LRM_HSRCH_BIT = 1;
   localparam int LRM_TSRCH_BIT = 0;
   localparam int LRM_S_CLR_BIT = 6;
   localparam int LRM_S_MIP_BIT = 5;
   localparam int LRM_S_TLF_BIT = 2;
   localparam int LRM_S_THF_BIT = 1;
   localparam int LRM_S_TAF_BIT = 0;
   // reset values
   localparam logic [7:0] LRM_TIME_RST = 8'h00;
   localparam logic [7:0] LRM_ONE_RST = 8'h01;
   localparam logic [7:0] LRM_CTRL_RST = 8'h80;
   // temperature code limits
   localparam logic [7:0] LRM_TEMP_MIN = 8'h00;
   localparam logic [7:0] LRM_TEMP_MAX = 8'hfa;
   // timing
   localparam int LRM_CLK_HZ = 25000000;
   localparam int LRM_SEC_CYC = LRM_CLK_HZ;
endpackage

// File: verification/lrm_core_sva.sv
module lrm_core_sva
   import lrm_pkg::*;
#(
   parameter int SEC_CYC = LRM_SEC_CYC
) (
   input wire logic i_clk, i_rst, i_wr, i_clear_cmd, i_conv_valid,
   input wire logic [9:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic signed [9:0] i_conv_raw,
   input wire logic [7:0] o_temp_code, o_sample_interval,
   input wire logic o_mission_active, o_cleared_flag, o_alarm_pulse, o_sec_tick, o_log_wrap_enable,
   input wire logic [15:0] o_start_delay
);
   logic stop_r, inh_r;
   wire ctrl_wr = i_wr && i_addr == LRM_CTRL_ADR;
   wire rate_wr = i_wr && i_addr == LRM_RATE_ADR;
   wire quiet_wr = !o_mission_active && !i_clear_cmd;
   wire prot_wr = i_wr && i_addr >= LRM_SEC_ADR && i_addr <= LRM_LAST_PROT_ADR;
   // ctrl is stored even mid-mission, so mirror every write
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stop_r <= 1'b1;
         inh_r <= 1'b0;
      end else if (ctrl_wr) begin
         stop_r <= i_wdata[LRM_OSC_BIT];
         inh_r <= i_wdata[LRM_INH_BIT];
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_TEMP_RANGE: assert property (o_temp_code <= LRM_TEMP_MAX)
      else $error("temperature code above top code");
   AST_CLAMP_LOW: assert property (i_conv_valid && i_conv_raw < 0 |=> o_temp_code == LRM_TEMP_MIN)
      else $error("low result not clamped");
   AST_CLAMP_HIGH: assert property (i_conv_valid && i_conv_raw > 10'sd250 |=> o_temp_code == LRM_TEMP_MAX)
      else $error("high result not clamped");
   AST_CODE_PASS: assert property (i_conv_valid && i_conv_raw >= 0 && i_conv_raw <= 10'sd250
      |=> o_temp_code == $past(i_conv_raw[7:0]))
      else $error("in-range code altered");
   AST_WR_ENDS: assert property (o_mission_active && prot_wr |=> !o_mission_active)
      else $error("write did not end mission");
   AST_START_COND: assert property ($rose(o_mission_active)
      |-> $past(rate_wr && i_wdata != 8'h00 && o_cleared_flag && !inh_r))
      else $error("mission started without its conditions");
   AST_RATE_STORE: assert property (rate_wr && quiet_wr |=> o_sample_interval == $past(i_wdata))
      else $error("sample interval not stored");
   AST_DELAY_LOW: assert property (i_wr && i_addr == LRM_DLYL_ADR && quiet_wr
      |=> o_start_delay[7:0] == $past(i_wdata))
      else $error("start delay low byte wrong");
   AST_WRAP_BIT: assert property (ctrl_wr |=> o_log_wrap_enable == $past(i_wdata[LRM_WRAP_BIT]))
      else $error("wrap enable does not follow ctrl");
   // holds only for SEC_CYC of 7 or more
   AST_TICK_GAP: assert property (o_sec_tick |=> !o_sec_tick [*6])
      else $error("second ticks too close");
   AST_OSC_STOP: assert property (o_sec_tick |-> !(stop_r && $past(stop_r)))
      else $error("tick while oscillator stopped");
   COV_START: cover property ($rose(o_mission_active));
   COV_ALARM: cover property (o_alarm_pulse);
   COV_CLAMP: cover property (i_conv_valid && i_conv_raw > 10'sd250);
endmodule

bind lrm_core lrm_core_sva #(.SEC_CYC(SEC_CYC)) u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr),
   .i_clear_cmd(i_clear_cmd), .i_conv_valid(i_conv_valid), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_conv_raw(i_conv_raw), .o_temp_code(o_temp_code), .o_sample_interval(o_sample_interval),
   .o_mission_active(o_mission_active), .o_cleared_flag(o_cleared_flag), .o_alarm_pulse(o_alarm_pulse),
   .o_sec_tick(o_sec_tick), .o_log_wrap_enable(o_log_wrap_enable), .o_start_delay(o_start_delay));

// File: verification/lrm_core_tb_top.sv
module lrm_core_tb_top;
   import lrm_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst, i_wr, i_rd, i_mem_cmd, i_clear_cmd, i_conv_valid;
   logic [9:0] i_addr;
   logic [7:0] i_wdata, o_rdata, o_temp_code, o_sample_interval;
   logic signed [9:0] i_conv_raw;
   logic o_mission_active, o_cleared_flag, o_alarm_pulse, o_sec_tick, o_log_wrap_enable, o_search_match;
   logic [15:0] o_start_delay;
   int err_count, samples_checked;
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   lrm_core #(.SEC_CYC(8)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_mem_cmd(i_mem_cmd), .i_clear_cmd(i_clear_cmd),
      .i_conv_valid(i_conv_valid), .i_conv_raw(i_conv_raw), .o_temp_code(o_temp_code),
      .o_mission_active(o_mission_active), .o_cleared_flag(o_cleared_flag), .o_alarm_pulse(o_alarm_pulse),
      .o_sec_tick(o_sec_tick), .o_log_wrap_enable(o_log_wrap_enable), .o_search_match(o_search_match),
      .o_start_delay(o_start_delay), .o_sample_interval(o_sample_interval));
   lrm_master u_mst (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_mem(i_mem_cmd),
      .o_clr(i_clear_cmd), .o_cv(i_conv_valid), .o_addr(i_addr), .o_wdata(i_wdata), .o_raw(i_conv_raw));
   task automatic end_sim();
      if (err_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [9:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_mst.rd(a, d);
      chk_byte(d, e);
   endtask
   task automatic wait_tick();
      int n;
      n = 0;
      while (o_sec_tick !== 1'b1 && n < 40) begin
         @(posedge i_clk) #1 n++;
      end
      chk_bit(o_sec_tick, 1'b1);
   endtask
   // one second of run, then stop so reads see a frozen clock
   task automatic one_sec(input logic [7:0] t[7], input logic [7:0] e[7]);
      for (int i = 0; i < 7; i++) u_mst.wr(LRM_SEC_ADR + 10'(i), t[i]);
      u_mst.wr(LRM_CTRL_ADR, 8'h00);
      wait_tick();
      u_mst.wr(LRM_CTRL_ADR, 8'h80);
      for (int i = 0; i < 7; i++) rc(LRM_SEC_ADR + 10'(i), e[i]);
   endtask
   task automatic t_fixed();
      logic [9:0] a[6] = '{LRM_SEC_ADR, LRM_WDAY_ADR, LRM_DATE_ADR, LRM_MON_ADR, LRM_CTRL_ADR, LRM_AWDAY_ADR};
      logic [7:0] m[6] = '{8'h7f, 8'h07, 8'h3f, 8'h9f, 8'hdf, 8'h87};
      rc(LRM_CTRL_ADR, LRM_CTRL_RST);
      rc(LRM_DATE_ADR, LRM_ONE_RST);
      for (int i = 0; i < 6; i++) begin
         u_mst.wr(a[i], 8'hff);
         rc(a[i], m[i]);
      end
      chk_bit(o_log_wrap_enable, 1'b1);
      rc(10'h20f, 8'h00);
   endtask
   task automatic t_leap();
      one_sec('{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h04},
         '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04});
   endtask
   task automatic t_noleap();
      one_sec('{8'h59, 8'h59, 8'h23, 8'h02, 8'h28, 8'h02, 8'h01},
         '{8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h03, 8'h01});
   endtask
   task automatic t_century();
      one_sec('{8'h59, 8'h59, 8'h71, 8'h03, 8'h31, 8'h12, 8'h99},
         '{8'h00, 8'h00, 8'h52, 8'h04, 8'h01, 8'h81, 8'h00});
   endtask
   task automatic t_alarm();
      u_mst.wr(LRM_SEC_ADR, 8'h03);
      u_mst.wr(LRM_ASEC_ADR, 8'h05);
      for (int i = 1; i < 4; i++) u_mst.wr(LRM_ASEC_ADR + 10'(i), 8'h80);
      u_mst.wr(LRM_STAT_ADR, 8'h00);
      u_mst.wr(LRM_CTRL_ADR, 8'h00);
      wait_tick();
      chk_bit(o_alarm_pulse, 1'b0);
      @(posedge i_clk) #1 wait_tick();
      chk_bit(o_alarm_pulse, 1'b1);
      u_mst.wr(LRM_CTRL_ADR, 8'h80);
      rc(LRM_STAT_ADR, 8'h81);
      u_mst.wr(LRM_STAT_ADR, 8'h00);
      rc(LRM_STAT_ADR, 8'h80);
      u_mst.wr(LRM_ASEC_ADR, 8'h80);
      u_mst.wr(LRM_CTRL_ADR, 8'h00);
      wait_tick();
      chk_bit(o_alarm_pulse, 1'b1);
      u_mst.wr(LRM_CTRL_ADR, 8'h81);
      chk_bit(o_search_match, 1'b1);
      u_mst.wr(LRM_CTRL_ADR, 8'h80);
      chk_bit(o_search_match, 1'b0);
   endtask
   task automatic t_temp();
      logic signed [9:0] r[7] = '{-10'sd5, 10'sd0, 10'sd1, 10'sd100, 10'sd250, 10'sd251, 10'sd400};
      logic [7:0] e[7] = '{8'h00, 8'h00, 8'h01, 8'h64, 8'hfa, 8'hfa, 8'hfa};
      for (int i = 0; i < 7; i++) begin
         u_mst.conv(r[i]);
         chk_byte(o_temp_code, e[i]);
      end
   endtask
   task automatic t_mission();
      u_mst.wr(LRM_CTRL_ADR, 8'h40);
      u_mst.clr_cmd();
      chk_bit(o_cleared_flag, 1'b1);
      u_mst.mem_cmd();
      rc(LRM_CTRL_ADR, 8'h00);
      wait_tick();
      u_mst.wr(LRM_CTRL_ADR, 8'h10);
      u_mst.wr(LRM_RATE_ADR, 8'h05);
      chk_bit(o_mission_active, 1'b0);
      u_mst.wr(LRM_CTRL_ADR, 8'h00);
      u_mst.wr(LRM_RATE_ADR, 8'h00);
      chk_bit(o_mission_active, 1'b0);
      u_mst.wr(LRM_DLYL_ADR, 8'h34);
      u_mst.wr(LRM_DLYH_ADR, 8'h12);
      chk_byte(o_start_delay[15:8], 8'h12);
      u_mst.wr(LRM_STAT_ADR, 8'h20);
      chk_bit(o_mission_active, 1'b0);
      u_mst.wr(LRM_RATE_ADR, 8'hff);
      chk_bit(o_mission_active, 1'b1);
      chk_bit(o_cleared_flag, 1'b0);
      rc(LRM_RATE_ADR, 8'hff);
      u_mst.wr(LRM_DLYL_ADR, 8'h77);
      chk_bit(o_mission_active, 1'b0);
      chk_byte(o_start_delay[7:0], 8'h34);
   endtask
   initial begin
      #2ms;
      err_count++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      end_sim();
   end
   initial begin
      i_rst = 1'b1;
      repeat (16) @(posedge i_clk);
      #1 i_rst = 1'b0;
      t_fixed();
      t_leap();
      t_noleap();
      t_century();
      t_alarm();
      t_temp();
      t_mission();
      end_sim();
   end
endmodule

// File: verification/lrm_master.sv
module lrm_master (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic o_wr, o_rd, o_mem, o_clr, o_cv,
   output logic [9:0] o_addr,
   output logic [7:0] o_wdata,
   output logic signed [9:0] o_raw
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {o_wr, o_rd, o_mem, o_clr, o_cv} = 5'h00;
      o_addr = 10'h000;
      o_wdata = 8'h00;
      o_raw = 10'h000;
   end
   // idle buses show the inverse of the last value, never a stale match
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk) #1 {o_wr, o_addr, o_wdata} = {1'b1, a, d};
      @(posedge i_clk) #1 {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge i_clk) #1 {o_rd, o_addr} = {1'b1, a};
      @(posedge i_clk) #1 {o_rd, o_addr} = {1'b0, ~a};
      d = i_rdata;
   endtask
   task automatic mem_cmd();
      @(posedge i_clk) #1 o_mem = 1'b1;
      @(posedge i_clk) #1 o_mem = 1'b0;
   endtask
   // clear must come before the next memory command after arming
   task automatic clr_cmd();
      @(posedge i_clk) #1 o_clr = 1'b1;
      @(posedge i_clk) #1 o_clr = 1'b0;
   endtask
   task automatic conv(input logic signed [9:0] r);
      @(posedge i_clk) #1 {o_cv, o_raw} = {1'b1, r};
      @(posedge i_clk) #1 {o_cv, o_raw} = {1'b0, ~r};
   endtask
endmodule
